// ### shared/servo_consts.svh
// timing counts, command codes and reset values of the servo command block
`ifndef SERVO_CONSTS_SVH
`define SERVO_CONSTS_SVH

`define CLK_PERIOD_NS     100
`define CLK_RATE_HZ       10000000
`define NR_GLITCH_NS      500
`define NR_CYCLES         ((`NR_GLITCH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PWM_REF_HZ        7350
`define FRAME_CYCLES      (`CLK_RATE_HZ / `PWM_REF_HZ)
`define FRAME_CNT_W       11
`define VCO_DIV_RATIO     2

`define CMD_MOTOR_ACCEL   8'h04
`define CMD_MOTOR_CLV     8'h05
`define CMD_MOTOR_BRAKE   8'h06
`define CMD_MOTOR_STOP    8'h07
`define CMD_NR_ON         8'hef
`define CMD_NR_OFF        8'hee
`define CMD_GAIN_SMALL    8'ha8
`define CMD_GAIN_LARGE    8'ha9
`define CMD_DIV_BYPASS    8'hb0
`define CMD_DIV_2         8'hb1
`define CMD_DIV_4         8'hb2
`define CMD_DIV_8         8'hb3
`define CMD_THREE_LEVEL   8'hb4
`define CMD_TWO_LEVEL     8'hb5
`define CMD_TRACK_OFF     8'h0f
`define CMD_TRACK_ON      8'h8f

`define RST_NOISE_REDUCE  1'b0
`define RST_GAIN_SMALL    1'b0
`define RST_DIV_SEL       2'h0
`define RST_THREE_LEVEL   1'b0
`define RST_TRACK_OFF     1'b0

`endif

// ### shared/servo_pkg.sv
// types shared by the servo command block
package servo_pkg;
	typedef enum logic [1:0] {
		MOTOR_ACCEL,
		MOTOR_CLV,
		MOTOR_BRAKE,
		MOTOR_STOP
	} motor_mode_t;
endpackage : servo_pkg

// ### shared/cmd_link_if.sv
// link between the command shifter and the command decoder
`timescale 1ns/1ns
`default_nettype none
interface cmd_link_if;
	logic       exec;
	logic [7:0] first_byte;
	logic [7:0] second_byte;
	logic       two_bytes;
	logic       noise_reduce;
	modport shifter (output exec, first_byte, second_byte, two_bytes, input noise_reduce);
	modport decoder (input exec, first_byte, second_byte, two_bytes, output noise_reduce);
endinterface : cmd_link_if
`default_nettype wire

// ### rtl/cmd_shift.sv
// serial command shifter with optional clock glitch filter
`timescale 1ns/1ns
`default_nettype none
`include "servo_consts.svh"
module cmd_shift (
	input  wire logic       clk_sys,
	input  wire logic       rst_b,
	input  wire logic       command_shift_clock_n,
	input  wire logic       command_serial_in,
	input  wire logic       command_strobe,
	cmd_link_if.shifter     link
);
	logic        clk_filt;
	logic        clk_prev;
	logic [2:0]  nr_cnt;
	logic [15:0] shreg;
	logic [4:0]  nbits;
	logic        strobe_q;
	logic        shift_edge;
	logic        strobe_fall;

	assign shift_edge  = clk_filt & ~clk_prev;
	assign strobe_fall = strobe_q & ~command_strobe;

	// R10 R20: shared clock glitch filter
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			clk_filt <= 1'b1;
			nr_cnt   <= 3'h0;
		end else if (!link.noise_reduce || command_shift_clock_n == clk_filt) begin
			clk_filt <= command_shift_clock_n;
			nr_cnt   <= 3'h0;
		end else if (nr_cnt == 3'(`NR_CYCLES - 1)) begin
			clk_filt <= command_shift_clock_n;
			nr_cnt   <= 3'h0;
		end else begin
			nr_cnt <= nr_cnt + 3'h1;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			clk_prev <= 1'b1;
			strobe_q <= 1'b0;
		end else begin
			clk_prev <= clk_filt;
			strobe_q <= command_strobe;
		end
	end

	// R23: msb first shift
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			shreg <= 16'h0000;
			nbits <= 5'h00;
		end else if (strobe_fall) begin
			nbits <= 5'h00;
		end else if (command_strobe && shift_edge) begin
			shreg <= {shreg[14:0], command_serial_in};
			if (nbits != 5'h10)
				nbits <= nbits + 5'h01;
		end
	end

	// R7 R8: hand over at strobe fall
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			link.exec        <= 1'b0;
			link.first_byte  <= 8'h00;
			link.second_byte <= 8'h00;
			link.two_bytes   <= 1'b0;
		end else begin
			link.exec <= strobe_fall && (nbits == 5'h08 || nbits == 5'h10);
			if (strobe_fall) begin
				link.two_bytes   <= nbits == 5'h10;
				link.first_byte  <= (nbits == 5'h10) ? shreg[15:8] : shreg[7:0];
				link.second_byte <= shreg[7:0];
			end
		end
	end
endmodule : cmd_shift
`default_nettype wire

// ### rtl/servo_command_spindle_control.sv
// servo command decoder and spindle motor control
`timescale 1ns/1ns
`default_nettype none
`include "servo_consts.svh"

// Summary of operation
// R1: defect floats slice output, holds level
// R2: defect hold only during phase control
// R3: vco monitor is divided vco clock
// R4: sync monitor rises on sync coincidence
// R5: sync monitor high one frame period
// R6: controller shifts bits while strobe high
// R7: commands act at strobe falling edge
// R8: one-byte and two-byte command framing
// R9: noise reduction on/off commands, off default
// R10: filter command clock glitches under 500ns
// R11: motor commands accel, clv, brake, stop
// R12: motor outputs per motor mode
// R13: tracking off low only in clv
// R14: pwm reference period 7.35 kHz
// R15: rough servo drives and indicator high
// R16: phase lock gives pwm, indicator low
// R17: small or large disc rough gain
// R18: phase comparator divisor select
// R19: three-level or two-level drive select
// R20: command clock shared, schmitt input
// R21: chip reset restores command defaults
// R22: three-level pin high, low or floating
// R23: msb first, eight bits per byte
module servo_command_spindle_control
	import servo_pkg::*;
#(
	parameter int VCO_DIV = `VCO_DIV_RATIO
) (
	input  wire logic       clk_sys,
	input  wire logic       rst_b,
	input  wire logic       chip_reset_n,
	input  wire logic       command_shift_clock_n,
	input  wire logic       command_serial_in,
	input  wire logic       command_strobe,
	input  wire logic       defect_detect_in,
	input  wire logic       vco_clk_in,
	input  wire logic       efm_frame_sync,
	input  wire logic       speed_too_low,
	input  wire logic       speed_too_high,
	input  wire logic [7:0] phase_duty,
	output logic            slice_level_oe_n,
	output logic            slice_level_hold,
	output logic            vco_divided_monitor,
	output logic            sync_detect_monitor,
	output logic            spindle_forward_out,
	output logic            spindle_forward_oe_n,
	output logic            spindle_reverse_out,
	output logic            velocity_phase_out,
	output logic            tracking_off_out,
	output logic            rough_gain_small,
	output logic [1:0]      phase_div_sel,
	output logic            three_level_mode
);
	localparam int FRAME = `FRAME_CYCLES;

	cmd_link_if link ();

	motor_mode_t              motor_mode;
	logic                     track_off_cmd;
	logic [`FRAME_CNT_W-1:0]  frame_cnt;
	logic [`FRAME_CNT_W-1:0]  sync_cnt;
	logic [`FRAME_CNT_W-1:0]  pwm_on;
	logic                     interp_sync;
	logic                     pwm_pulse;
	logic                     vco_q;
	logic                     vco_rise;
	logic [7:0]               vco_cnt;
	logic                     rough_servo;
	logic                     next_fwd;
	logic                     next_rev;
	logic                     next_vp;
	logic                     one_byte;

	// R6: strobe framed shifting
	cmd_shift u_shift (
		.clk_sys               (clk_sys),
		.rst_b                 (rst_b),
		.command_shift_clock_n (command_shift_clock_n),
		.command_serial_in     (command_serial_in),
		.command_strobe        (command_strobe),
		.link                  (link.shifter)
	);

	// two-byte payloads belong to attenuation and port logic elsewhere
	assign one_byte = link.exec && !link.two_bytes;

	// R11: motor mode commands
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			motor_mode <= MOTOR_STOP;
		end else if (!chip_reset_n) begin
			// R21: reset to defaults
			motor_mode <= MOTOR_STOP;
		end else if (one_byte) begin
			case (link.first_byte)
				`CMD_MOTOR_ACCEL: motor_mode <= MOTOR_ACCEL;
				`CMD_MOTOR_CLV:   motor_mode <= MOTOR_CLV;
				`CMD_MOTOR_BRAKE: motor_mode <= MOTOR_BRAKE;
				`CMD_MOTOR_STOP:  motor_mode <= MOTOR_STOP;
				default:          motor_mode <= motor_mode;
			endcase
		end
	end

	// R9: noise reduction toggle
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			link.noise_reduce <= `RST_NOISE_REDUCE;
		end else if (!chip_reset_n) begin
			link.noise_reduce <= `RST_NOISE_REDUCE;
		end else if (one_byte && link.first_byte == `CMD_NR_ON) begin
			link.noise_reduce <= 1'b1;
		end else if (one_byte && link.first_byte == `CMD_NR_OFF) begin
			link.noise_reduce <= 1'b0;
		end
	end

	// R17: rough servo gain
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rough_gain_small <= `RST_GAIN_SMALL;
		end else if (!chip_reset_n) begin
			rough_gain_small <= `RST_GAIN_SMALL;
		end else if (one_byte && link.first_byte == `CMD_GAIN_SMALL) begin
			rough_gain_small <= 1'b1;
		end else if (one_byte && link.first_byte == `CMD_GAIN_LARGE) begin
			rough_gain_small <= 1'b0;
		end
	end

	// R18: comparator divisor
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			phase_div_sel <= `RST_DIV_SEL;
		end else if (!chip_reset_n) begin
			phase_div_sel <= `RST_DIV_SEL;
		end else if (one_byte && link.first_byte[7:2] == 6'(`CMD_DIV_BYPASS >> 2)) begin
			phase_div_sel <= link.first_byte[1:0];
		end
	end

	// R19: drive style select
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			three_level_mode <= `RST_THREE_LEVEL;
		end else if (!chip_reset_n) begin
			three_level_mode <= `RST_THREE_LEVEL;
		end else if (one_byte && link.first_byte == `CMD_THREE_LEVEL) begin
			three_level_mode <= 1'b1;
		end else if (one_byte && link.first_byte == `CMD_TWO_LEVEL) begin
			three_level_mode <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			track_off_cmd <= `RST_TRACK_OFF;
		end else if (!chip_reset_n) begin
			track_off_cmd <= `RST_TRACK_OFF;
		end else if (one_byte && link.first_byte == `CMD_TRACK_OFF) begin
			track_off_cmd <= 1'b1;
		end else if (one_byte && link.first_byte == `CMD_TRACK_ON) begin
			track_off_cmd <= 1'b0;
		end
	end

	// R13: tracking off gating
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b)
			tracking_off_out <= 1'b1;
		else
			tracking_off_out <= (motor_mode != MOTOR_CLV) || track_off_cmd;
	end

	// R14: frame and pwm timebase
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b)
			frame_cnt <= '0;
		else if (frame_cnt == `FRAME_CNT_W'(FRAME - 1))
			frame_cnt <= '0;
		else
			frame_cnt <= frame_cnt + `FRAME_CNT_W'(1);
	end

	assign interp_sync = frame_cnt == '0;
	// duty times five spans most of the 1360-cycle period
	assign pwm_on    = `FRAME_CNT_W'({phase_duty, 2'b00}) + `FRAME_CNT_W'(phase_duty);
	assign pwm_pulse = frame_cnt < pwm_on;
	assign rough_servo = speed_too_low || speed_too_high;

	// R12: motor output selection
	always_comb begin
		next_fwd = 1'b0;
		next_rev = 1'b0;
		next_vp  = 1'b1;
		case (motor_mode)
			MOTOR_ACCEL: next_fwd = 1'b1;
			MOTOR_BRAKE: next_rev = 1'b1;
			MOTOR_CLV: begin
				// R15: rough servo
				if (speed_too_low) begin
					next_fwd = 1'b1;
				end else if (speed_too_high) begin
					next_rev = 1'b1;
				end else begin
					// R16: phase locked pwm
					next_fwd = pwm_pulse;
					next_rev = ~pwm_pulse;
					next_vp  = 1'b0;
				end
			end
			default: begin
				next_fwd = 1'b0;
				next_rev = 1'b0;
			end
		endcase
	end

	// R22: three-level single pin
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			spindle_forward_out  <= 1'b0;
			spindle_forward_oe_n <= 1'b0;
			spindle_reverse_out  <= 1'b0;
			velocity_phase_out   <= 1'b1;
		end else begin
			velocity_phase_out <= next_vp;
			if (three_level_mode) begin
				spindle_forward_out  <= next_fwd;
				spindle_forward_oe_n <= ~(next_fwd ^ next_rev);
				spindle_reverse_out  <= 1'b0;
			end else begin
				spindle_forward_out  <= next_fwd;
				spindle_forward_oe_n <= 1'b0;
				spindle_reverse_out  <= next_rev;
			end
		end
	end

	// R1: defect slice hold
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			slice_level_oe_n <= 1'b0;
			slice_level_hold <= 1'b0;
		end else begin
			// R2: phase control only
			slice_level_oe_n <= defect_detect_in && !velocity_phase_out;
			slice_level_hold <= defect_detect_in && !velocity_phase_out;
		end
	end

	assign vco_rise = vco_clk_in && !vco_q;

	// R3: vco divider
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			vco_q               <= 1'b0;
			vco_cnt             <= 8'h00;
			vco_divided_monitor <= 1'b0;
		end else begin
			vco_q <= vco_clk_in;
			if (vco_rise) begin
				if (vco_cnt == 8'(VCO_DIV / 2 - 1)) begin
					vco_cnt             <= 8'h00;
					vco_divided_monitor <= ~vco_divided_monitor;
				end else begin
					vco_cnt <= vco_cnt + 8'h01;
				end
			end
		end
	end

	// R4: sync coincidence
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			sync_cnt            <= '0;
			sync_detect_monitor <= 1'b0;
		end else if (efm_frame_sync && interp_sync) begin
			sync_cnt            <= `FRAME_CNT_W'(FRAME - 1);
			sync_detect_monitor <= 1'b1;
		end else if (sync_cnt != '0) begin
			// R5: one frame high
			sync_cnt <= sync_cnt - `FRAME_CNT_W'(1);
		end else begin
			sync_detect_monitor <= 1'b0;
		end
	end

	// helper: length of each sync monitor high run
	int hi_len;
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b)
			hi_len <= 0;
		else if (sync_detect_monitor)
			hi_len <= hi_len + 1;
		else
			hi_len <= 0;
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	property p_slice_hold;
		(defect_detect_in && !velocity_phase_out) |=> (slice_level_oe_n && slice_level_hold);
	endproperty
	a_slice_hold: assert property (p_slice_hold) else $error("slice not held on defect"); // R1

	property p_defect_ignored;
		(!defect_detect_in || velocity_phase_out) |=> !slice_level_oe_n;
	endproperty
	a_defect_ignored: assert property (p_defect_ignored) else $error("defect not ignored"); // R2

	property p_vco_step;
		$changed(vco_divided_monitor) |-> $past(vco_clk_in && !vco_q);
	endproperty
	a_vco_step: assert property (p_vco_step) else $error("vco monitor moved without vco edge"); // R3

	property p_sync_rise;
		(efm_frame_sync && frame_cnt == '0) |=> sync_detect_monitor ##1 sync_detect_monitor[*8];
	endproperty
	a_sync_rise: assert property (p_sync_rise) else $error("sync monitor not raised"); // R4

	property p_sync_len;
		$fell(sync_detect_monitor) |-> (hi_len % FRAME == 0);
	endproperty
	a_sync_len: assert property (p_sync_len) else $error("sync monitor run not a frame"); // R5

	property p_exec_at_fall;
		link.exec |-> ($past(command_strobe, 2) && !$past(command_strobe));
	endproperty
	a_exec_at_fall: assert property (p_exec_at_fall) else $error("command run off strobe"); // R7

	property p_nr_on;
		(one_byte && link.first_byte == `CMD_NR_ON && chip_reset_n) |=> link.noise_reduce;
	endproperty
	a_nr_on: assert property (p_nr_on) else $error("noise reduction not enabled"); // R9

	property p_mode_hold;
		$changed(motor_mode) |-> ($past(one_byte) || !$past(chip_reset_n));
	endproperty
	a_mode_hold: assert property (p_mode_hold) else $error("motor mode moved unbidden"); // R11

	property p_accel_drive;
		(motor_mode == MOTOR_ACCEL && !three_level_mode) [*2] |->
			(spindle_forward_out && !spindle_reverse_out);
	endproperty
	a_accel_drive: assert property (p_accel_drive) else $error("accelerate drive wrong"); // R12

	property p_tracking_off_out_high;
		(motor_mode != MOTOR_CLV) |=> tracking_off_out;
	endproperty
	a_tracking_off_out_high: assert property (p_tracking_off_out_high) else $error("tracking off low outside clv"); // R13

	property p_frame_wrap;
		(frame_cnt == `FRAME_CNT_W'(FRAME - 1)) |=> (frame_cnt == '0);
	endproperty
	a_frame_wrap: assert property (p_frame_wrap) else $error("pwm period wrong"); // R14

	property p_rough_vp;
		(motor_mode == MOTOR_CLV && rough_servo) |=> velocity_phase_out;
	endproperty
	a_rough_vp: assert property (p_rough_vp) else $error("indicator low in rough servo"); // R15

	property p_reset_defaults;
		!chip_reset_n |=> (motor_mode == MOTOR_STOP && !link.noise_reduce && !three_level_mode
			&& !rough_gain_small && phase_div_sel == `RST_DIV_SEL);
	endproperty
	a_reset_defaults: assert property (p_reset_defaults) else $error("defaults not restored"); // R21

	c_accel: cover property (one_byte && link.first_byte == `CMD_MOTOR_ACCEL);
	c_sync: cover property ($rose(sync_detect_monitor));
	c_float: cover property (three_level_mode && spindle_forward_oe_n);
	c_lock: cover property ($fell(velocity_phase_out));
endmodule : servo_command_spindle_control
`default_nettype wire

// ### test/cmd_host_model.sv
// behavioural control processor that shifts servo commands in
`timescale 1ns/1ns
`default_nettype none
module cmd_host_model (
	input  wire logic clk_sys,
	output logic      command_shift_clock_n,
	output logic      command_serial_in,
	output logic      command_strobe
);
	initial begin
		command_shift_clock_n = 1'b1;
		command_serial_in     = 1'b0;
		command_strobe        = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : tick

	// strobe high, msb first, one bit per clock
	task automatic send(input logic [15:0] v, input int nbits, input int hold, input bit glitch);
		command_strobe <= 1'b1;
		tick(2);
		for (int i = nbits - 1; i >= 0; i--) begin
			command_serial_in     <= v[i];
			command_shift_clock_n <= 1'b0;
			tick(hold);
			// spike of 200 ns inside the low phase
			if (glitch) begin
				command_shift_clock_n <= 1'b1;
				tick(2);
				command_shift_clock_n <= 1'b0;
				tick(hold);
			end
			command_shift_clock_n <= 1'b1;
			tick(hold);
		end
		// strobe fall executes; released data line stops showing the last bit
		command_strobe    <= 1'b0;
		command_serial_in <= ~command_serial_in;
		tick(2);
	endtask : send
endmodule : cmd_host_model
`default_nettype wire

// ### test/servo_command_spindle_control_test.sv
// self-checking bench for the servo command and spindle block
`timescale 1ns/1ns
`default_nettype none
module servo_command_spindle_control_test import servo_pkg::*;;
	localparam int VDIV = 2;
	logic        clk_sys = 1'b0;
	logic        rst_b, chip_reset_n, defect_detect_in, vco_clk_in, efm_frame_sync;
	logic        speed_too_low, speed_too_high, cnt_en, cnt_clr, mon_prev;
	logic [7:0]  phase_duty;
	logic        command_shift_clock_n, command_serial_in, command_strobe;
	logic        slice_level_oe_n, slice_level_hold, vco_divided_monitor, sync_detect_monitor;
	logic        spindle_forward_out, spindle_forward_oe_n, spindle_reverse_out;
	logic        velocity_phase_out, tracking_off_out, rough_gain_small, three_level_mode;
	logic [1:0]  phase_div_sel, div;
	logic [15:0] cnt [3];
	logic [17:0] note;
	logic [10:0] q_vec [$];
	logic [17:0] q_cnt [$];
	event        ev_vec, ev_cnt;
	motor_mode_t mode;
	logic        tracking_off_out_set, gain, three;
	int          hold, num_errors = 0, total_checks = 0;
	logic [7:0]  cmds [21] = '{8'h04, 8'h05, 8'h0f, 8'h8f, 8'h06, 8'h07, 8'h0f, 8'h05, 8'h8f,
		8'ha8, 8'hb1, 8'hb2, 8'hb3, 8'hb4, 8'h04, 8'h06, 8'h05, 8'h07, 8'hb5, 8'hb0, 8'ha9};
	// floated pin reads as 0 so its stale value never matters
	wire logic [10:0] act_vec = {~spindle_forward_oe_n & spindle_forward_out,
		spindle_forward_oe_n, spindle_reverse_out, velocity_phase_out, tracking_off_out,
		rough_gain_small, phase_div_sel, three_level_mode, slice_level_oe_n, slice_level_hold};

	always #50 clk_sys = ~clk_sys;

	cmd_host_model host (.clk_sys, .command_shift_clock_n, .command_serial_in, .command_strobe);

	servo_command_spindle_control #(.VCO_DIV(VDIV)) uut (.clk_sys, .rst_b, .chip_reset_n,
		.command_shift_clock_n, .command_serial_in, .command_strobe, .defect_detect_in,
		.vco_clk_in, .efm_frame_sync, .speed_too_low, .speed_too_high, .phase_duty,
		.slice_level_oe_n, .slice_level_hold, .vco_divided_monitor, .sync_detect_monitor,
		.spindle_forward_out, .spindle_forward_oe_n, .spindle_reverse_out,
		.velocity_phase_out, .tracking_off_out, .rough_gain_small, .phase_div_sel,
		.three_level_mode);

	// counters for pulse widths, toggles and duty
	always @(posedge clk_sys) begin
		mon_prev <= vco_divided_monitor;
		if (cnt_clr) begin
			cnt <= '{default: 16'h0000};
		end else if (cnt_en) begin
			cnt[0] <= cnt[0] + 16'(spindle_forward_out);
			cnt[1] <= cnt[1] + 16'(vco_divided_monitor != mon_prev);
			cnt[2] <= cnt[2] + 16'(sync_detect_monitor);
		end
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : tick

	task automatic finish_test();
		$display("total_checks %0d num_errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : finish_test

	task automatic compare(input logic [15:0] e, input logic [15:0] a);
		total_checks++;
		if (a !== e) begin
			num_errors++;
			$display("ERROR t=%0t exp=%h got=%h", $time, e, a);
		end
	endtask : compare

	task automatic check_vec(input logic [10:0] e, input logic [10:0] a);
		compare({5'h00, e}, {5'h00, a});
	endtask : check_vec

	task automatic check_cnt(input logic [15:0] e, input logic [15:0] a);
		compare(e, a);
	endtask : check_cnt

	always @(ev_vec) check_vec(q_vec.pop_front(), act_vec);

	always @(ev_cnt) begin
		note = q_cnt.pop_front();
		check_cnt(note[15:0], cnt[note[17:16]]);
	end

	function automatic logic [10:0] expv();
		logic f, r, vp, oe, sl;
		f = 1'b0;
		r = 1'b0;
		vp = 1'b1;
		case (mode)
			MOTOR_ACCEL: f = 1'b1;
			MOTOR_BRAKE: r = 1'b1;
			MOTOR_CLV: begin
				if (speed_too_low) f = 1'b1;
				else if (speed_too_high) r = 1'b1;
				else begin
					// zero duty in lock: reverse held high
					vp = 1'b0;
					r = 1'b1;
				end
			end
			default: ;
		endcase
		oe = three & (f == r);
		sl = defect_detect_in & ~vp;
		return {~oe & f, oe, r & ~three, vp, (mode != MOTOR_CLV) | tracking_off_out_set, gain, div,
			three, sl, sl};
	endfunction : expv

	function automatic void decode(input logic [7:0] c);
		if (c[7:2] == 6'h01) mode = motor_mode_t'(c[1:0]);
		if (c[7:1] == 7'h54) gain = ~c[0];
		if (c[7:2] == 6'h2c) div = c[1:0];
		if (c[7:1] == 7'h5a) three = ~c[0];
		if (c == 8'h0f) tracking_off_out_set = 1'b1;
		if (c == 8'h8f) tracking_off_out_set = 1'b0;
		if (c[7:1] == 7'h77) hold = c[0] ? 7 : 2;
	endfunction : decode

	function automatic void defaults();
		mode = MOTOR_STOP;
		{tracking_off_out_set, gain, div, three} = 5'h00;
		hold = 2;
	endfunction : defaults

	task automatic settle();
		tick(4);
		q_vec.push_back(expv());
		-> ev_vec;
	endtask : settle

	task automatic do_cmd(input logic [7:0] c);
		host.send({8'h00, c}, 8, hold, 1'b0);
		decode(c);
		settle();
	endtask : do_cmd

	task automatic measure(input int sel, input logic [15:0] e, input int n);
		cnt_clr <= 1'b1;
		tick(1);
		cnt_clr <= 1'b0;
		cnt_en  <= 1'b1;
		tick(n);
		cnt_en <= 1'b0;
		tick(1);
		q_cnt.push_back({2'(sel), e});
		-> ev_cnt;
	endtask : measure

	initial begin
		tick(60000);
		num_errors++;
		finish_test();
	end

	initial begin
		void'($urandom(32'hd5942861));
		rst_b = 1'b0;
		chip_reset_n = 1'b1;
		{defect_detect_in, vco_clk_in, efm_frame_sync, speed_too_low, speed_too_high} = 5'h00;
		{cnt_en, cnt_clr, phase_duty} = 10'h000;
		defaults();
		tick(3);
		rst_b <= 1'b1;
		settle();
		foreach (cmds[i]) begin
			do_cmd(cmds[i]);
		end
		do_cmd(8'h05);
		speed_too_low <= 1'b1;
		settle();
		speed_too_low  <= 1'b0;
		speed_too_high <= 1'b1;
		settle();
		defect_detect_in <= 1'b1;
		settle();
		speed_too_high <= 1'b0;
		settle();
		defect_detect_in <= 1'b0;
		// two bytes in one strobe and odd counts leave settings alone
		host.send(16'h0706, 16, hold, 1'b0);
		settle();
		host.send(16'h0107, 9, hold, 1'b0);
		settle();
		host.send(16'h0004, 8, hold, 1'b1);
		settle();
		do_cmd(8'hef);
		host.send(16'h0004, 8, hold, 1'b1);
		decode(8'h04);
		settle();
		do_cmd(8'hee);
		host.send(16'h0006, 8, hold, 1'b1);
		settle();
		do_cmd(8'hef);
		do_cmd(8'ha8);
		do_cmd(8'hb4);
		chip_reset_n <= 1'b0;
		tick(2);
		chip_reset_n <= 1'b1;
		defaults();
		settle();
		host.send(16'h0004, 8, hold, 1'b1);
		settle();
		do_cmd(8'h05);
		phase_duty <= 8'($urandom_range(1, 255));
		tick(1400);
		measure(0, {8'h00, phase_duty} * 16'd5, 1360);
		fork
			measure(1, 16'(12 / VDIV), 60);
			begin
				tick(2);
				repeat (6) begin
					vco_clk_in <= 1'b1;
					tick(2);
					vco_clk_in <= 1'b0;
					tick(2);
				end
			end
		join
		fork
			measure(2, 16'd1360, 3000);
			begin
				tick(2);
				efm_frame_sync <= 1'b1;
				tick(1360);
				efm_frame_sync <= 1'b0;
			end
		join
		tick(2);
		finish_test();
	end
endmodule : servo_command_spindle_control_test
`default_nettype wire
